/* File: core/gpio_port_bank_pkg.sv */
// constants for the general purpose port bank: register map, field layout, reset values
// assumes a byte wide register port on the system clock, addresses in i/o space
package gpio_port_bank_pkg;

  // ==========================================================================
  // widths
  localparam int NUM_PORTS  = 6;
  localparam int PORT_W     = 8;
  localparam int ADDR_W     = 8;
  localparam int PJ_SRC_W   = 7;

  // ==========================================================================
  // register map, entry 0 is port a, entry 5 is port f
  localparam logic [NUM_PORTS-1:0][ADDR_W-1:0] PIN_INPUT_ADDR =
    {8'h0f, 8'h0c, 8'h09, 8'h06, 8'h03, 8'h00};
  localparam logic [NUM_PORTS-1:0][ADDR_W-1:0] DIRECTION_ADDR =
    {8'h10, 8'h0d, 8'h0a, 8'h07, 8'h04, 8'h01};
  localparam logic [NUM_PORTS-1:0][ADDR_W-1:0] OUTPUT_LATCH_ADDR =
    {8'h11, 8'h0e, 8'h0b, 8'h08, 8'h05, 8'h02};
  localparam logic [ADDR_W-1:0] MCU_GLOBAL_CONTROL_ADDR = 8'h35;
  localparam logic [ADDR_W-1:0] PIN_CHANGE_STATUS_ADDR  = 8'h20;
  localparam logic [ADDR_W-1:0] PIN_CHANGE_MASK_ADDR    = 8'h21;

  // ==========================================================================
  // control register fields
  localparam int DEBUG_INTERFACE_DISABLE_BIT = 7;
  localparam int BROWNOUT_SLEEP_OFF_BIT      = 6;
  localparam int BROWNOUT_SLEEP_UNLOCK_BIT   = 5;
  localparam int GLOBAL_PULLUP_KILL_BIT      = 4;
  localparam int VECTOR_TABLE_SELECT_BIT     = 1;
  localparam int VECTOR_CHANGE_UNLOCK_BIT    = 0;
  localparam logic [PORT_W-1:0] MCU_CONTROL_WRITABLE = 8'h93;

  // ==========================================================================
  // reset values
  localparam logic [PORT_W-1:0] PORT_RESET    = 8'h00;
  localparam logic [PORT_W-1:0] MCU_RESET     = 8'h00;
  localparam logic [PORT_W-1:0] READ_IDLE     = 8'h00;
  localparam logic [PJ_SRC_W-1:0] EVENT_RESET = 7'h00;

  // ==========================================================================
  // port j override table: bit 7 has no pin change source
  localparam logic [PORT_W-1:0] PJ_CHANGE_CAPABLE   = 8'h7f;
  localparam logic [PORT_W-1:0] PJ_OVERRIDE_VALUE   = 8'h00;
  localparam logic [PORT_W-1:0] PJ_OVERRIDE_OFF     = 8'h00;

endpackage : gpio_port_bank_pkg

/* File: core/gpio_port_bank.sv */
// ports a to f with latch, direction and input registers, global pull-up kill,
// and the port j alternate function override signals for pin change sensing
// assumes one clock, synchronous reset, pad inputs asynchronous to the clock
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps

module gpio_port_bank (
  input  wire logic                   CLOCK,
  input  wire logic                   SYS_RST,
  input  wire logic [7:0]             ADDR,
  input  wire logic [7:0]             WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output logic      [7:0]             RDATA,
  input  wire logic [47:0]            PAD_IN,
  output logic      [47:0]            PAD_OUT,
  output logic      [47:0]            PAD_OE,
  output logic      [47:0]            PAD_PULLUP,
  input  wire logic [7:0]             PJ_PAD_IN,
  input  wire logic [7:0]             PJ_CHANGE_MASK,
  input  wire logic                   PIN_CHANGE_GROUP0_ENABLE,
  output logic      [6:0]             PIN_CHANGE_SRC,
  output logic      [7:0]             INPUT_BUFFER_OVERRIDE_ENABLE,
  output logic      [7:0]             INPUT_BUFFER_OVERRIDE_VALUE,
  output logic      [7:0]             PULLUP_OVERRIDE_ENABLE,
  output logic      [7:0]             PULLUP_OVERRIDE_VALUE,
  output logic      [7:0]             DIRECTION_OVERRIDE_ENABLE,
  output logic      [7:0]             DIRECTION_OVERRIDE_VALUE,
  output logic      [7:0]             OUTPUT_VALUE_OVERRIDE_ENABLE,
  output logic      [7:0]             OUTPUT_VALUE_OVERRIDE_VALUE,
  output logic                        DEBUG_INTERFACE_DISABLE,
  output logic                        VECTOR_TABLE_SELECT,
  output logic                        VECTOR_CHANGE_UNLOCK,
  output logic                        IRQ
);

  localparam int NP = gpio_port_bank_pkg::NUM_PORTS;
  localparam int W  = gpio_port_bank_pkg::PORT_W;
  localparam int JW = gpio_port_bank_pkg::PJ_SRC_W;

  // ==========================================================================
  // address decode
  // one-hot hit against a table of six port addresses
  function automatic logic [NP-1:0] port_hit(
    input logic [7:0]         addr,
    input logic [NP-1:0][7:0] table_addr
  );
    logic [NP-1:0] hit;
    hit = '0;
    for (int i = 0; i < NP; i++) begin
      hit[i] = (addr == table_addr[i]);
    end
    return hit;
  endfunction : port_hit

  logic [NP-1:0] pin_hit;
  logic [NP-1:0] dir_hit;
  logic [NP-1:0] latch_hit;

  assign pin_hit   = port_hit(ADDR, gpio_port_bank_pkg::PIN_INPUT_ADDR);
  assign dir_hit   = port_hit(ADDR, gpio_port_bank_pkg::DIRECTION_ADDR);
  assign latch_hit = port_hit(ADDR, gpio_port_bank_pkg::OUTPUT_LATCH_ADDR);

  // ==========================================================================
  // pad synchronisers
  // stage one is read only by stage two, so no metastable value leaks out
  logic [47:0] pad_meta_r;
  logic [47:0] pad_sync_r;
  logic [7:0]  pj_meta_r;
  logic [7:0]  pj_sync_r;
  logic [7:0]  pj_prev_r;

  always_ff @(posedge CLOCK) begin
    pad_meta_r <= PAD_IN;
    pad_sync_r <= pad_meta_r;
    pj_meta_r  <= PJ_PAD_IN;
    pj_sync_r  <= pj_meta_r;
    pj_prev_r  <= pj_sync_r;
  end

  // ==========================================================================
  // port registers
  logic [NP-1:0][W-1:0] latch_r;
  logic [NP-1:0][W-1:0] dir_r;
  logic [7:0]           mcu_r;

  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_port
      // latch write; a one written to the pin input toggles the latch bit
      always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
          latch_r[p] <= gpio_port_bank_pkg::PORT_RESET;
        end else if (WR && latch_hit[p]) begin
          latch_r[p] <= WDATA;
        end else if (WR && pin_hit[p]) begin
          latch_r[p] <= latch_r[p] ^ WDATA;
        end
      end

      // direction write
      always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
          dir_r[p] <= gpio_port_bank_pkg::PORT_RESET;
        end else if (WR && dir_hit[p]) begin
          dir_r[p] <= WDATA;
        end
      end

      // pad drive: direction 1 drives the latch value
      assign PAD_OUT[p*W +: W] = latch_r[p];
      assign PAD_OE[p*W +: W]  = dir_r[p];
      assign PAD_PULLUP[p*W +: W] = ~dir_r[p] & latch_r[p]
        & {W{~mcu_r[gpio_port_bank_pkg::GLOBAL_PULLUP_KILL_BIT]}};
    end
  endgenerate

  // ==========================================================================
  // mcu global control register
  // control register fields
  // brown-out bits stay zero here; their owner sits outside this block
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      mcu_r <= gpio_port_bank_pkg::MCU_RESET;
    end else if (WR && ADDR == gpio_port_bank_pkg::MCU_GLOBAL_CONTROL_ADDR) begin
      mcu_r <= WDATA & gpio_port_bank_pkg::MCU_CONTROL_WRITABLE;
    end
  end

  assign DEBUG_INTERFACE_DISABLE =
    mcu_r[gpio_port_bank_pkg::DEBUG_INTERFACE_DISABLE_BIT];
  assign VECTOR_TABLE_SELECT  = mcu_r[gpio_port_bank_pkg::VECTOR_TABLE_SELECT_BIT];
  assign VECTOR_CHANGE_UNLOCK = mcu_r[gpio_port_bank_pkg::VECTOR_CHANGE_UNLOCK_BIT];

  // ==========================================================================
  // port j pin change sources and overrides
  // sources 24 to 30
  assign PIN_CHANGE_SRC = pj_sync_r[JW-1:0];

  // bits 0 to 6 override
  // bit 7 is masked off by the capable set, so it never overrides
  assign INPUT_BUFFER_OVERRIDE_ENABLE = PJ_CHANGE_MASK
    & {W{PIN_CHANGE_GROUP0_ENABLE}} & gpio_port_bank_pkg::PJ_CHANGE_CAPABLE;
  assign INPUT_BUFFER_OVERRIDE_VALUE  = gpio_port_bank_pkg::PJ_OVERRIDE_VALUE;

  assign PULLUP_OVERRIDE_ENABLE       = gpio_port_bank_pkg::PJ_OVERRIDE_OFF;
  assign PULLUP_OVERRIDE_VALUE        = gpio_port_bank_pkg::PJ_OVERRIDE_OFF;
  assign DIRECTION_OVERRIDE_ENABLE    = gpio_port_bank_pkg::PJ_OVERRIDE_OFF;
  assign DIRECTION_OVERRIDE_VALUE     = gpio_port_bank_pkg::PJ_OVERRIDE_OFF;
  assign OUTPUT_VALUE_OVERRIDE_ENABLE = gpio_port_bank_pkg::PJ_OVERRIDE_OFF;
  assign OUTPUT_VALUE_OVERRIDE_VALUE  = gpio_port_bank_pkg::PJ_OVERRIDE_OFF;

  // ==========================================================================
  // pin change events, sticky status and mask
  logic [JW-1:0] change_evt;
  logic [JW-1:0] status_r;
  logic [JW-1:0] status_nxt;
  logic [JW-1:0] mask_r;

  assign change_evt = pj_sync_r[JW-1:0] ^ pj_prev_r[JW-1:0];

  // write one to clear, a fresh event in the same cycle wins
  always_comb begin
    status_nxt = status_r;
    if (WR && ADDR == gpio_port_bank_pkg::PIN_CHANGE_STATUS_ADDR) begin
      status_nxt = status_r & ~WDATA[JW-1:0];
    end
    status_nxt = status_nxt | change_evt;
  end

  // first cycle after reset ignores the unsettled history register
  logic evt_armed_r;
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      status_r    <= gpio_port_bank_pkg::EVENT_RESET;
      evt_armed_r <= 1'b0;
    end else begin
      evt_armed_r <= 1'b1;
      status_r    <= evt_armed_r ? status_nxt : gpio_port_bank_pkg::EVENT_RESET;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      mask_r <= gpio_port_bank_pkg::EVENT_RESET;
    end else if (WR && ADDR == gpio_port_bank_pkg::PIN_CHANGE_MASK_ADDR) begin
      mask_r <= WDATA[JW-1:0];
    end
  end

  assign IRQ = |(status_r & mask_r);

  // ==========================================================================
  // read data, one cycle after the strobe and only then
  logic [7:0] rdata_nxt;

  always_comb begin
    rdata_nxt = gpio_port_bank_pkg::READ_IDLE;
    for (int i = 0; i < NP; i++) begin
      if (pin_hit[i]) begin
        rdata_nxt = pad_sync_r[i*W +: W];
      end
      if (dir_hit[i]) begin
        rdata_nxt = dir_r[i];
      end
      if (latch_hit[i]) begin
        rdata_nxt = latch_r[i];
      end
    end
    if (ADDR == gpio_port_bank_pkg::MCU_GLOBAL_CONTROL_ADDR) begin
      rdata_nxt = mcu_r;
    end
    if (ADDR == gpio_port_bank_pkg::PIN_CHANGE_STATUS_ADDR) begin
      rdata_nxt = {1'b0, status_r};
    end
    if (ADDR == gpio_port_bank_pkg::PIN_CHANGE_MASK_ADDR) begin
      rdata_nxt = {1'b0, mask_r};
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      RDATA <= gpio_port_bank_pkg::READ_IDLE;
    end else if (RD) begin
      RDATA <= rdata_nxt;
    end else begin
      RDATA <= gpio_port_bank_pkg::READ_IDLE;
    end
  end

endmodule : gpio_port_bank

/* File: dv/gpio_port_bank_checker.sv */
// assertions on the pins and register port of the port bank
// assumes binding to every gpio_port_bank instance, one clock domain
`timescale 1ns/1ps

module gpio_port_bank_checker (
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  input wire logic [7:0]  ADDR,
  input wire logic [7:0]  WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [7:0]  RDATA,
  input wire logic [47:0] PAD_OUT,
  input wire logic [47:0] PAD_OE,
  input wire logic [47:0] PAD_PULLUP,
  input wire logic [7:0]  PJ_PAD_IN,
  input wire logic [7:0]  PJ_CHANGE_MASK,
  input wire logic        PIN_CHANGE_GROUP0_ENABLE,
  input wire logic [6:0]  PIN_CHANGE_SRC,
  input wire logic [7:0]  INPUT_BUFFER_OVERRIDE_ENABLE,
  input wire logic [7:0]  INPUT_BUFFER_OVERRIDE_VALUE,
  input wire logic [7:0]  PULLUP_OVERRIDE_ENABLE
);
  // ==========================================================================
  // clocking: reset cycles excluded, registers are held there
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  // ==========================================================================
  // port j overrides and pin change source
  chk_ibuf_ovr_en: assert property (
    INPUT_BUFFER_OVERRIDE_ENABLE == {1'b0, PJ_CHANGE_MASK[6:0] & {7{PIN_CHANGE_GROUP0_ENABLE}}})
    else $error("input buffer override enable wrong");
  chk_ibuf_ovr_val: assert property ((INPUT_BUFFER_OVERRIDE_VALUE | PULLUP_OVERRIDE_ENABLE) == '0)
    else $error("override not held at zero");
  chk_src_follow: assert property (PIN_CHANGE_SRC == $past(PJ_PAD_IN[6:0], 2))
    else $error("pin change source not two cycles behind pad");

  // ==========================================================================
  // pull-up and control register
  chk_kill_pullup: assert property ((WR && ADDR == 8'h35 && WDATA[4]) |=> PAD_PULLUP == '0)
    else $error("pull-up survives kill bit");
  chk_pullup_cfg: assert property ((PAD_PULLUP & (PAD_OE | ~PAD_OUT)) == '0)
    else $error("pull-up outside input with latch one");
  chk_ctrl_rsvd: assert property ((RD && ADDR == 8'h35) |=> (RDATA & 8'h6c) == 8'h00)
    else $error("read-only control bits not zero");

  // ==========================================================================
  // per port: writes reach the pads, direction reads match the pads
  for (genvar p = 0; p < 6; p++) begin : g_port
    chk_dir_oe: assert property (
      (WR && ADDR == gpio_port_bank_pkg::DIRECTION_ADDR[p]) |=> PAD_OE[p*8+:8] == $past(WDATA))
      else $error("direction write not on pad enable");
    chk_latch_out: assert property (
      (WR && ADDR == gpio_port_bank_pkg::OUTPUT_LATCH_ADDR[p]) |=> PAD_OUT[p*8+:8] == $past(WDATA))
      else $error("latch write not on pad output");
    chk_dir_read: assert property (
      (RD && ADDR == gpio_port_bank_pkg::DIRECTION_ADDR[p]) |=> RDATA == PAD_OE[p*8+:8])
      else $error("direction read differs from pad enable");
  end

  // main scenarios reached
  cov_kill: cover property (WR && ADDR == 8'h35 && WDATA[4]);
  cov_src: cover property (PIN_CHANGE_SRC[6]);
  cov_ovr: cover property (INPUT_BUFFER_OVERRIDE_ENABLE != 8'h00);
endmodule : gpio_port_bank_checker

bind gpio_port_bank gpio_port_bank_checker i_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE),
  .PAD_PULLUP(PAD_PULLUP), .PJ_PAD_IN(PJ_PAD_IN), .PJ_CHANGE_MASK(PJ_CHANGE_MASK),
  .PIN_CHANGE_GROUP0_ENABLE(PIN_CHANGE_GROUP0_ENABLE), .PIN_CHANGE_SRC(PIN_CHANGE_SRC),
  .INPUT_BUFFER_OVERRIDE_ENABLE(INPUT_BUFFER_OVERRIDE_ENABLE),
  .INPUT_BUFFER_OVERRIDE_VALUE(INPUT_BUFFER_OVERRIDE_VALUE),
  .PULLUP_OVERRIDE_ENABLE(PULLUP_OVERRIDE_ENABLE));

/* File: dv/gpio_pad_world.sv */
// package pins outside the port bank: external drivers, pull-ups, floating pins
// assumes the bench sets which pins an outside driver holds
`timescale 1ns/1ps

module gpio_pad_world (
  input wire logic        clock,
  input wire logic [47:0] pad_out,
  input wire logic [47:0] pad_oe,
  input wire logic [47:0] pad_pullup,
  input wire logic [47:0] ext_val,
  input wire logic [47:0] ext_en,
  output logic     [47:0] pad_in
);
  logic flip_r = 1'b0;

  // a floating pin wanders, so nothing may rely on its last value
  always_ff @(posedge clock) begin
    flip_r <= ~flip_r;
  end

  // own driver first, then outside driver, then pull-up, else floating
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                | (~pad_oe & ~ext_en & (pad_pullup | {48{flip_r}}));
endmodule : gpio_pad_world

/* File: dv/gpio_port_bank_tb.sv */
// self-checking bench for the port bank over its register port
// assumes the pad model beside the design and a 200 MHz clock
`timescale 1ns/1ps

module gpio_port_bank_tb;
  logic        clock, sys_rst, wr, rd, grp_en, irq;
  logic [7:0]  addr, wdata, rdata, pj_pad, pj_mask, ibuf_en, v, d;
  logic [7:0]  ibuf_val, pu_en, pu_val, dir_en, dir_val, out_en, out_val;
  logic        dbg_dis, vec_sel, vec_unl;
  logic [47:0] pad_in, pad_out, pad_oe, pad_pu, ext_val, ext_en;
  logic [6:0]  chg_src;
  int          errors, check_count;

  gpio_port_bank i_dut (.CLOCK(clock), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe),
    .PAD_PULLUP(pad_pu), .PJ_PAD_IN(pj_pad), .PJ_CHANGE_MASK(pj_mask),
    .PIN_CHANGE_GROUP0_ENABLE(grp_en), .PIN_CHANGE_SRC(chg_src),
    .INPUT_BUFFER_OVERRIDE_ENABLE(ibuf_en), .INPUT_BUFFER_OVERRIDE_VALUE(ibuf_val),
    .PULLUP_OVERRIDE_ENABLE(pu_en), .PULLUP_OVERRIDE_VALUE(pu_val),
    .DIRECTION_OVERRIDE_ENABLE(dir_en), .DIRECTION_OVERRIDE_VALUE(dir_val),
    .OUTPUT_VALUE_OVERRIDE_ENABLE(out_en), .OUTPUT_VALUE_OVERRIDE_VALUE(out_val),
    .DEBUG_INTERFACE_DISABLE(dbg_dis), .VECTOR_TABLE_SELECT(vec_sel),
    .VECTOR_CHANGE_UNLOCK(vec_unl), .IRQ(irq));
  gpio_pad_world i_pads (.clock(clock), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pu),
    .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

  // ==========================================================================
  // clock, watchdog, compare and close
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // the whole run is about 125 cycles, far below this span
  initial begin
    #20000;
    errors++;
    end_sim();
  end
  task automatic check(string what, logic [47:0] seen, logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  // one-cycle strobes, launched and dropped right after rising edges
  task automatic reg_wr(logic [7:0] a, logic [7:0] dat);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= dat;
    @(posedge clock);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(logic [7:0] a, output logic [7:0] dat);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 dat = rdata;
  endtask : reg_rd

  // ==========================================================================
  // tests
  initial begin
    {sys_rst, wr, rd, grp_en, addr, wdata, pj_pad, errors, check_count} = '0;
    sys_rst = 1'b1;
    pj_mask = 8'ha5;
    ext_val = {6{8'h3c}};
    ext_en = '1;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    // per port: reset values, readback, pad level and pull-up
    for (int p = 0; p < 6; p++) begin
      d = 8'h5a ^ 8'(p);
      reg_rd(gpio_port_bank_pkg::DIRECTION_ADDR[p], v);
      check("dir reset", v, 0);
      reg_rd(gpio_port_bank_pkg::OUTPUT_LATCH_ADDR[p], v);
      check("latch reset", v, 0);
      reg_wr(gpio_port_bank_pkg::DIRECTION_ADDR[p], d);
      reg_wr(gpio_port_bank_pkg::OUTPUT_LATCH_ADDR[p], 8'hc3);
      reg_rd(gpio_port_bank_pkg::OUTPUT_LATCH_ADDR[p], v);
      check("latch", v, 8'hc3);
      reg_rd(gpio_port_bank_pkg::PIN_INPUT_ADDR[p], v);
      check("pin", v, (d & 8'hc3) | (~d & 8'h3c));
      check("pullup", pad_pu[p*8+:8], ~d & 8'hc3);
    end
    // control register: writable mask, kill bit, then restore
    reg_rd(8'h35, v);
    check("ctrl reset", v, 0);
    reg_wr(8'h35, 8'hff);
    reg_rd(8'h35, v);
    check("ctrl", v, 8'h93);
    check("ctrl pins", {dbg_dis, vec_sel, vec_unl}, 3'h7);
    check("killed", pad_pu, 0);
    reg_wr(8'h35, 8'h00);
    #1 check("restored", pad_pu[7:0], 8'h81);
    check("ctrl pins off", {dbg_dis, vec_sel, vec_unl}, 3'h0);
    // outside drivers let go: pulled-up bits read one, floating bits wander
    @(posedge clock);
    ext_en <= '0;
    repeat (3) @(posedge clock);
    reg_rd(gpio_port_bank_pkg::PIN_INPUT_ADDR[0], v);
    check("pulled", v & 8'hdb, 8'hc3);
    ext_en <= '1;
    // a one written to a pin input register flips that latch bit
    reg_wr(gpio_port_bank_pkg::PIN_INPUT_ADDR[0], 8'h0f);
    reg_rd(gpio_port_bank_pkg::OUTPUT_LATCH_ADDR[0], v);
    check("latch toggle", v, 8'hcc);
    // unmapped place ignores writes and reads zero
    reg_wr(8'h40, 8'hff);
    reg_rd(8'h40, v);
    check("unmapped", v, 0);
    // input buffer override with group enable off then on
    for (int g = 0; g < 2; g++) begin
      @(posedge clock);
      grp_en <= g[0];
      @(posedge clock);
      #1 check("ibuf", ibuf_en, g ? 8'h25 : 8'h00);
    end
    check("overrides", {ibuf_val, pu_en, pu_val, dir_en, dir_val, out_en}, 0);
    check("out override value", out_val, 0);
    // pin change on bits 6 and 2, interrupt masked, unmasked, cleared
    @(posedge clock);
    pj_pad <= 8'h44;
    repeat (5) @(posedge clock);
    #1 check("src", chg_src, 7'h44);
    check("irq masked", irq, 0);
    reg_rd(8'h20, v);
    check("status", v, 8'h44);
    reg_wr(8'h21, 8'h40);
    #1 check("irq on", irq, 1);
    reg_wr(8'h20, 8'h40);
    #1 check("irq off", irq, 0);
    reg_rd(8'h20, v);
    check("status left", v, 8'h04);
    // clear and a fresh change of bit 2 meet in one cycle: the change wins
    @(posedge clock);
    pj_pad <= 8'h40;
    @(posedge clock);
    reg_wr(8'h20, 8'h04);
    reg_rd(8'h20, v);
    check("set wins", v, 8'h04);
    end_sim();
  end
endmodule : gpio_port_bank_tb
